// file: verilog/qrsp_regs.svh
`ifndef QRSP_REGS_SVH
`define QRSP_REGS_SVH
// data path width, lane layout, address widths and burst timing
`define QRSP_DW        18
`define QRSP_LANES     2
`define QRSP_LANE_W    9
`define QRSP_AW        19
`define QRSP_MEM_AW    8
`define QRSP_BEATS     4
`define QRSP_BEAT_W    2
`define QRSP_BEAT_LAST 2'h3
`define QRSP_READ_LAT  2'h1
`endif

// file: verilog/qrsp_pkg.sv
package qrsp_pkg;
   `include "qrsp_regs.svh"
   typedef logic [`QRSP_DW-1:0]    qrsp_data_t;
   typedef logic [`QRSP_LANES-1:0] qrsp_mask_t;
   typedef logic [`QRSP_AW-1:0]    qrsp_addr_t;
   typedef enum logic {QRSP_RANGE_LOW, QRSP_RANGE_HIGH} qrsp_range_t;
endpackage

// file: verilog/qrsp_sram_port.sv
`timescale 1ns/1ns
module qrsp_sram_port
(
   input  wire logic                 core_clk,
   input  wire logic                 rst_n,
   input  wire logic                 in_clk_p,
   input  wire logic                 in_clk_n,
   input  wire logic                 write_port_sel_n,
   input  wire logic                 read_port_sel_n,
   input  wire qrsp_pkg::qrsp_addr_t addr,
   input  wire qrsp_pkg::qrsp_data_t wr_data,
   input  wire qrsp_pkg::qrsp_mask_t byte_lane_mask_n,
   input  wire logic                 term_range_sel,
   output logic                      echo_strobe_p,
   output logic                      echo_strobe_n,
   output qrsp_pkg::qrsp_data_t      rd_data,
   output logic                      rd_data_oe,
   output logic                      read_valid_flag,
   output qrsp_pkg::qrsp_range_t     term_range
);
   import qrsp_pkg::*;

   localparam int DEPTH = 1 << `QRSP_MEM_AW;

   // storage kept small; upper address bits alias
   qrsp_data_t mem [0:DEPTH-1];

   logic [1:0]   kp_sync_q, kn_sync_q, wps_q, rps_q, rng_q;
   logic         kp_last_q, kn_last_q;
   qrsp_addr_t   a_s1_q, a_s2_q;
   qrsp_data_t   d_s1_q, d_s2_q;
   qrsp_mask_t   m_s1_q, m_s2_q;
   logic         kp_rise, kn_rise, beat_edge;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         kp_sync_q <= 2'h0;
         kn_sync_q <= 2'h0;
         wps_q     <= 2'h3;
         rps_q     <= 2'h3;
         rng_q     <= 2'h3;
         a_s1_q    <= '0;
         a_s2_q    <= '0;
         d_s1_q    <= '0;
         d_s2_q    <= '0;
         m_s1_q    <= '1;
         m_s2_q    <= '1;
      end else begin
         kp_sync_q <= {kp_sync_q[0], in_clk_p};
         kn_sync_q <= {kn_sync_q[0], in_clk_n};
         wps_q     <= {wps_q[0], write_port_sel_n};
         rps_q     <= {rps_q[0], read_port_sel_n};
         rng_q     <= {rng_q[0], term_range_sel};
         a_s1_q    <= addr;
         a_s2_q    <= a_s1_q;
         d_s1_q    <= wr_data;
         d_s2_q    <= d_s1_q;
         m_s1_q    <= byte_lane_mask_n;
         m_s2_q    <= m_s1_q;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         kp_last_q <= 1'b0;
         kn_last_q <= 1'b0;
      end else begin
         kp_last_q <= kp_sync_q[1];
         kn_last_q <= kn_sync_q[1];
      end
   end

   assign kp_rise   = kp_sync_q[1] & ~kp_last_q;
   assign kn_rise   = kn_sync_q[1] & ~kn_last_q;
   assign beat_edge = kp_rise | kn_rise;

   // strap caught once after reset release, held until next reset
   logic rng_done_q;
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rng_done_q <= 1'b0;
         term_range <= QRSP_RANGE_HIGH;
      end else if (!rng_done_q && kp_rise) begin
         rng_done_q <= 1'b1;
         // floating pin reads high, so high range is the default
         term_range <= rng_q[1] ? QRSP_RANGE_HIGH : QRSP_RANGE_LOW;
      end
   end

   // echo clock mirrors the sampled input clock, runs whenever it runs
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         echo_strobe_p <= 1'b0;
         echo_strobe_n <= 1'b1;
      end else begin
         echo_strobe_p <= kp_sync_q[1];
         echo_strobe_n <= ~kp_sync_q[1];
      end
   end

   // write burst: four beats on alternating p/n edges
   logic                    wr_act_q;
   logic [`QRSP_BEAT_W-1:0] wr_beat_q;
   logic [`QRSP_MEM_AW-1:0] wr_base_q;
   logic [`QRSP_MEM_AW-1:0] wr_idx;
   logic                    wr_start;

   assign wr_start = kp_rise & ~wps_q[1] & (~wr_act_q | wr_beat_q ==
                     `QRSP_BEAT_LAST);

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_act_q  <= 1'b0;
         wr_beat_q <= '0;
         wr_base_q <= '0;
      end else if (beat_edge) begin
         if (wr_start) begin
            wr_act_q  <= 1'b1;
            wr_beat_q <= '0;
            // address kept only when the port is selected
            wr_base_q <= {a_s2_q[`QRSP_MEM_AW-`QRSP_BEAT_W-1:0],
                          {`QRSP_BEAT_W{1'b0}}};
         end else if (wr_act_q) begin
            wr_beat_q <= wr_beat_q + 1'b1;
            if (wr_beat_q == `QRSP_BEAT_LAST)
               wr_act_q <= 1'b0;
         end
      end
   end

   assign wr_idx = wr_start ? {a_s2_q[`QRSP_MEM_AW-`QRSP_BEAT_W-1:0],
                   {`QRSP_BEAT_W{1'b0}}}
                 : wr_base_q + {{(`QRSP_MEM_AW-`QRSP_BEAT_W){1'b0}},
                   wr_beat_q + 1'b1};

   // data only looked at while a write burst owns the edge
   always_ff @(posedge core_clk) begin
      if (beat_edge && (wr_start || (wr_act_q && wr_beat_q !=
          `QRSP_BEAT_LAST))) begin
         for (int l = 0; l < `QRSP_LANES; l++) begin
            if (!m_s2_q[l])
               mem[wr_idx][l*`QRSP_LANE_W +: `QRSP_LANE_W] <=
                  d_s2_q[l*`QRSP_LANE_W +: `QRSP_LANE_W];
         end
      end
   end

   // read burst: one cycle latency, then four beats
   logic                    rd_pend_q, rd_act_q;
   logic [`QRSP_BEAT_W-1:0] rd_beat_q;
   logic [`QRSP_MEM_AW-1:0] rd_base_q, rd_next_q;
   logic                    rd_start;

   assign rd_start = kp_rise & ~rps_q[1];

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_pend_q <= 1'b0;
         rd_act_q  <= 1'b0;
         rd_beat_q <= '0;
         rd_base_q <= '0;
         rd_next_q <= '0;
      end else if (beat_edge) begin
         if (rd_start && (!rd_act_q || rd_beat_q == `QRSP_BEAT_LAST ||
             rd_beat_q == `QRSP_READ_LAT)) begin
            rd_pend_q <= 1'b1;
            // kept apart so a running burst keeps its own base
            rd_next_q <= {a_s2_q[`QRSP_MEM_AW-`QRSP_BEAT_W-1:0],
                          {`QRSP_BEAT_W{1'b0}}};
         end
         if (rd_pend_q && kp_rise) begin
            rd_pend_q <= rd_start;
            rd_act_q  <= 1'b1;
            rd_base_q <= rd_next_q;
            rd_beat_q <= '0;
         end else if (rd_act_q) begin
            rd_beat_q <= rd_beat_q + 1'b1;
            // pending burst completes before the drivers float
            if (rd_beat_q == `QRSP_BEAT_LAST)
               rd_act_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_data         <= '0;
         rd_data_oe      <= 1'b0;
         read_valid_flag <= 1'b0;
      end else if (beat_edge) begin
         if (rd_pend_q && kp_rise) begin
            rd_data         <= mem[rd_next_q];
            rd_data_oe      <= 1'b1;
            read_valid_flag <= 1'b1;
         end else if (rd_act_q && rd_beat_q != `QRSP_BEAT_LAST) begin
            rd_data <= mem[rd_base_q + {{(`QRSP_MEM_AW-`QRSP_BEAT_W){1'b0}},
                       rd_beat_q + 1'b1}];
         end else begin
            rd_data_oe      <= 1'b0;
            read_valid_flag <= 1'b0;
         end
      end
   end
endmodule

// file: tb/qrsp_ctrl_model.sv
`timescale 1ns/1ns
module qrsp_ctrl_model (
   input  wire logic      core_clk,
   output logic           in_clk_p,
   output logic           in_clk_n,
   output logic           write_port_sel_n,
   output logic           read_port_sel_n,
   output qrsp_pkg::qrsp_addr_t addr,
   output qrsp_pkg::qrsp_data_t wr_data,
   output qrsp_pkg::qrsp_mask_t byte_lane_mask_n
);
   import qrsp_pkg::*;
   // start phase puts the first input clock rise on reset release
   logic [2:0] ph = 3'h6;
   // input clock runs free so the echo never stalls
   assign in_clk_p = !ph[2];
   assign in_clk_n = ph[2];
   always @(negedge core_clk) ph <= ph + 3'h1;
   initial begin
      write_port_sel_n = 1'b1;
      read_port_sel_n = 1'b1;
      addr = '0;
      wr_data = '0;
      byte_lane_mask_n = '1;
   end
   // one core cycle of setup, three of hold, per link edge
   task automatic op(input logic w, input logic r, input qrsp_addr_t a,
                     input logic [71:0] d, input logic [7:0] m);
      for (int i = 0; i < 4; i++) begin
         @(negedge core_clk iff ph == (i[0] ? 3'h2 : 3'h6));
         write_port_sel_n <= (i == 0) ? !w : 1'b1;
         read_port_sel_n <= (i == 0) ? !r : 1'b1;
         addr <= (i == 0) ? a : ~a;
         wr_data <= d[18*i +: 18];
         byte_lane_mask_n <= m[2*i +: 2];
      end
   endtask
endmodule

// file: tb/qrsp_props.sv
`timescale 1ns/1ns
module qrsp_props (
   input wire logic                  core_clk,
   input wire logic                  rst_n,
   input wire logic                  in_clk_p,
   input wire qrsp_pkg::qrsp_data_t  rd_data,
   input wire logic                  rd_data_oe,
   input wire logic                  read_valid_flag,
   input wire logic                  echo_strobe_p,
   input wire logic                  echo_strobe_n,
   input wire qrsp_pkg::qrsp_range_t term_range
);
   import qrsp_pkg::*;
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);
   sequence s_kp;
      $rose(echo_strobe_p);
   endsequence
   sequence s_burst;
      rd_data_oe ##8 rd_data_oe ##6 rd_data_oe;
   endsequence
   a_valid_oe: assert property (read_valid_flag == rd_data_oe)
      else $error("valid flag differs from output enable");
   a_echo_pair: assert property (echo_strobe_n == !echo_strobe_p)
      else $error("echo pair not complementary");
   a_echo_runs: assert property ($changed(echo_strobe_p) |-> ##[3:5]
      $changed(echo_strobe_p)) else $error("echo clock stalled");
   a_echo_follow: assert property ($rose(in_clk_p) |-> ##[2:4]
      echo_strobe_p) else $error("echo does not follow input clock");
   a_burst_len: assert property ($rose(rd_data_oe) |-> s_burst)
      else $error("read burst shorter than four beats");
   a_oe_start: assert property ($rose(rd_data_oe) |-> s_kp)
      else $error("burst not started on positive edge");
   a_oe_stop: assert property ($fell(rd_data_oe) |-> s_kp)
      else $error("outputs not floated on positive edge");
   a_beat_edge: assert property (rd_data_oe && $past(rd_data_oe) &&
      $changed(rd_data) |-> $changed(echo_strobe_p))
      else $error("read beat changed off a clock edge");
   a_range_hold: assert property ($changed(term_range) |->
      $past(term_range) == QRSP_RANGE_HIGH) else $error("range relatched");
endmodule

// file: tb/tb.sv
`timescale 1ns/1ns
module tb;
   import qrsp_pkg::*;
   logic        core_clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        term_range_sel = 1'b0;
   logic        in_clk_p, in_clk_n, write_port_sel_n, read_port_sel_n;
   logic        echo_strobe_p, echo_strobe_n, rd_data_oe, read_valid_flag;
   logic        e1, e2;
   qrsp_addr_t  addr;
   qrsp_data_t  wr_data, rd_data;
   qrsp_data_t  mem [256];
   qrsp_data_t  expq [$];
   qrsp_mask_t  byte_lane_mask_n;
   qrsp_range_t term_range;
   logic [31:0] seed = 32'h86950e2b;
   int          bad_count = 0, n_checks = 0, cyc = 0;
   qrsp_sram_port dut (.core_clk, .rst_n, .in_clk_p, .in_clk_n,
      .write_port_sel_n, .read_port_sel_n, .addr, .wr_data,
      .byte_lane_mask_n, .term_range_sel, .echo_strobe_p, .echo_strobe_n,
      .rd_data, .rd_data_oe, .read_valid_flag, .term_range);
   qrsp_ctrl_model m0 (.core_clk, .in_clk_p, .in_clk_n, .write_port_sel_n,
      .read_port_sel_n, .addr, .wr_data, .byte_lane_mask_n);
   initial forever #20 core_clk = !core_clk;
   function automatic logic [71:0] r72();
      for (int i = 0; i < 3; i++)
         seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return {seed, seed, seed[7:0]};
   endfunction
   task automatic chk(input logic [17:0] got, input logic [17:0] exp);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic summarize();
      $display("checks %0d errors %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic wr(input qrsp_addr_t a, input logic [7:0] m);
      logic [71:0] d;
      d = r72();
      for (int i = 0; i < 8; i++)
         if (!m[i]) mem[{a[5:0], i[2:1]}][9*i[0] +: 9] = d[9*i +: 9];
      m0.op(1'b1, 1'b0, a, d, m);
   endtask
   task automatic rd(input qrsp_addr_t a);
      for (int i = 0; i < 4; i++) expq.push_back(mem[{a[5:0], i[1:0]}]);
      m0.op(1'b0, 1'b1, a, r72(), 8'h00);
   endtask
   // deselected cycles carry live masks and changing data to be ignored
   task automatic idle();
      m0.op(1'b0, 1'b0, 19'(r72()), r72(), 8'h00);
   endtask
   task automatic rst(input logic s);
      term_range_sel = s;
      rst_n = 1'b0;
      repeat (2) @(negedge core_clk);
      rst_n = 1'b1;
      repeat (16) @(negedge core_clk);
      chk(18'(term_range), 18'(s ? QRSP_RANGE_HIGH : QRSP_RANGE_LOW));
   endtask
   always @(negedge core_clk) begin
      e1 <= echo_strobe_p;
      e2 <= e1;
      if (e1 !== e2 && read_valid_flag === 1'b1)
         chk(rd_data, expq.size() ? expq.pop_front() : 18'hx);
   end
   always @(posedge core_clk) begin
      cyc++;
      if (cyc > 5000) begin
         bad_count++;
         summarize();
      end
   end
   initial begin
      rst(1'b0);
      for (int i = 0; i < 8; i++) wr(19'(i), 8'h00);
      for (int i = 0; i < 8; i++) wr(19'(i), 8'(r72()));
      repeat (3) idle();
      for (int i = 0; i < 8; i++) rd(19'(i));
      repeat (3) idle();
      rd(19'h5);
      repeat (3) idle();
      chk(18'(expq.size()), 18'h0);
      rst(1'b1);
      summarize();
   end
endmodule
bind qrsp_sram_port qrsp_props p (.core_clk, .rst_n, .in_clk_p, .rd_data,
   .rd_data_oe, .read_valid_flag, .echo_strobe_p, .echo_strobe_n,
   .term_range);
